// *** verilog/sccs_pkg.sv ***
// Shared constants and types for the system clock source select block
package sccs_pkg;

    // Timing
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned FAIL_SAFE_CLOCK_MONITOR_TIMEOUT_NS = 100000;
    localparam int unsigned FAIL_SAFE_CLOCK_MONITOR_TIMEOUT_CYC = FAIL_SAFE_CLOCK_MONITOR_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int unsigned FAIL_CNT_W = 16;
    localparam int unsigned OST_CYCLES = 1024;
    localparam int unsigned OST_W = 11;

    // Register indices; byte address is four times the index
    localparam logic [7:0] OSC_CTRL_IDX = 8'h8f;
    localparam logic [7:0] IRQ_STAT_IDX = 8'h90;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h91;
    localparam logic [7:0] INFO_IDX = 8'h92;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_MSB = 9;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Oscillator control fields
    localparam int unsigned FREQ_MSB = 6;
    localparam int unsigned FREQ_LSB = 4;
    localparam int unsigned EXT_BIT = 3;
    localparam int unsigned HTS_BIT = 2;
    localparam int unsigned LTS_BIT = 1;
    localparam int unsigned SCS_BIT = 0;
    localparam logic [2:0] FREQ_RST = 3'h6;
    localparam logic [2:0] FREQ_LF_CODE = 3'h0;

    // Info register fields
    localparam int unsigned INFO_KHZ_MSB = 15;
    localparam int unsigned INFO_MODE_LSB = 16;
    localparam int unsigned INFO_MODE_MSB = 18;
    localparam int unsigned INFO_OST_BIT = 19;
    localparam int unsigned INFO_FAIL_BIT = 20;
    localparam int unsigned INFO_SEL_LSB = 21;
    localparam int unsigned INFO_SEL_MSB = 23;

    // Interrupt status bits
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_FAIL = 0;
    localparam int unsigned IRQ_OST = 1;
    localparam int unsigned IRQ_SWITCH = 2;

    // Internal oscillator frequency per select code, in kHz
    localparam logic [15:0] FREQ_KHZ [8] = '{
        16'h001f, 16'h007d, 16'h00fa, 16'h01f4,
        16'h03e8, 16'h07d0, 16'h0fa0, 16'h1f40
    };

    typedef enum logic [2:0] {
        MODE_LOW_GAIN = 3'h0,
        MODE_MED_GAIN = 3'h1,
        MODE_HIGH_GAIN = 3'h2,
        MODE_EXT_CLK = 3'h3,
        MODE_INT_IO = 3'h4,
        MODE_INT_CLKOUT = 3'h5,
        MODE_RC_IO = 3'h6,
        MODE_RC = 3'h7
    } sccs_mode_t;

    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_EXT = 3'h1,
        SRC_HF = 3'h2,
        SRC_LF = 3'h4
    } sccs_src_t;

    typedef enum logic [3:0] {
        ST_INIT = 4'h1,
        ST_RUN = 4'h2,
        ST_DROP = 4'h4,
        ST_TAKE = 4'h8
    } sccs_state_t;

    typedef struct packed {
        logic ext_clk;
        logic hf_clk;
        logic lf_clk;
        logic hf_stable;
        logic lf_stable;
        logic wake;
    } sccs_pins_t;

endpackage : sccs_pkg

// *** verilog/sccs_sync.sv ***
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module sccs_sync #(
    parameter int W = 6
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sccs_sync_regs_t;

    sccs_sync_regs_t r_q;
    sccs_sync_regs_t r_d;

    always_comb begin
        r_d.s1 = d_in;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign q_out = r_q.s2;

endmodule : sccs_sync

// *** verilog/sccs_top.sv ***
// System clock source selection, oscillator control register and fail-safe monitor
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module sccs_top
    import sccs_pkg::*;
#(
    parameter int FAIL_SAFE_CLOCK_MONITOR_TIMEOUT_CYCLES = FAIL_SAFE_CLOCK_MONITOR_TIMEOUT_CYC,
    parameter int OST_COUNT = OST_CYCLES
) (
    input wire logic CLOCK_IN,
    input wire logic NRST_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire logic [2:0] CLOCK_MODE_IN,
    input wire logic TWO_SPEED_STARTUP_ENABLE_IN,
    input wire logic FAIL_SAFE_CLOCK_MONITOR_IN,
    input wire logic OSC_PIN_CLK_IN,
    input wire logic HF_OSC_CLK_IN,
    input wire logic LF_OSC_CLK_IN,
    input wire logic HF_STABLE_IN,
    input wire logic LF_STABLE_IN,
    input wire logic WAKE_IN,
    output logic [2:0] SRC_SEL_OUT,
    output logic [2:0] HF_FREQ_SEL_OUT,
    output logic EXEC_HOLD_OUT,
    output logic PORTA_PIN6_GPIO_OUT,
    output logic PORTA_PIN6_CLKOUT_OUT,
    output logic PORTA_PIN6_CLK_OUT,
    output logic PORTA_PIN7_GPIO_OUT,
    output logic IRQ_OUT
);

    localparam logic [OST_W-1:0] OST_LAST = OST_W'(OST_COUNT - 1);
    localparam logic [FAIL_CNT_W-1:0] FAIL_LAST = FAIL_CNT_W'(FAIL_SAFE_CLOCK_MONITOR_TIMEOUT_CYCLES - 1);

    typedef struct packed {
        sccs_state_t st;
        sccs_mode_t cfg_mode;
        logic two_speed;
        logic fail_safe_clock_monitor;
        logic ext_prev;
        logic wake_prev;
        logic clk_prev;
        logic div;
        logic pin6_clk;
        logic pin6_gpio;
        logic pin6_co;
        logic pin7_gpio;
        logic [OST_W-1:0] ost_cnt;
        logic ost_done;
        logic fail;
        logic [FAIL_CNT_W-1:0] fail_cnt;
        sccs_src_t sel;
        logic hold;
        logic [2:0] freq;
        logic system_clock_select;
        logic ext_flag;
        logic high_freq_internal_stable;
        logic low_freq_internal_stable;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_idx;
        logic [31:0] rdata;
        logic rdy;
        logic resp;
    } sccs_regs_t;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisation

    logic [1:0] rst_sync_q;
    logic rst_n;
    sccs_pins_t pins_raw;
    sccs_pins_t ps;

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    assign pins_raw = '{
        ext_clk: OSC_PIN_CLK_IN,
        hf_clk: HF_OSC_CLK_IN,
        lf_clk: LF_OSC_CLK_IN,
        hf_stable: HF_STABLE_IN,
        lf_stable: LF_STABLE_IN,
        wake: WAKE_IN
    };

    sccs_sync #(
        .W($bits(sccs_pins_t))
    ) u_sync (
        .clk_in(CLOCK_IN),
        .rst_n_in(rst_n),
        .d_in(pins_raw),
        .q_out(ps)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    sccs_regs_t q;
    sccs_regs_t d;
    sccs_mode_t m;
    logic ts_en;
    logic fail_safe_clock_monitor_en;
    logic crystal;
    logic internal_osc_clkout_mode;
    sccs_src_t int_src;
    sccs_src_t pri_src;
    sccs_src_t tgt;
    logic ext_rise;
    logic wake_rise;
    logic cur_clk;
    logic new_clk;
    logic clk_rise;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;
    logic ap;
    logic hit;
    logic [31:0] rd;

    always_comb begin
        d = q;
        ev = '0;
        w1c = '0;
        rd = '0;

        // Configuration word is live only in the first cycle after reset
        if (q.st == ST_INIT) begin
            m = sccs_mode_t'(CLOCK_MODE_IN);
            fail_safe_clock_monitor_en = FAIL_SAFE_CLOCK_MONITOR_IN;
            ts_en = TWO_SPEED_STARTUP_ENABLE_IN | FAIL_SAFE_CLOCK_MONITOR_IN;
        end else begin
            m = q.cfg_mode;
            fail_safe_clock_monitor_en = q.fail_safe_clock_monitor;
            ts_en = q.two_speed;
        end
        crystal = m inside {MODE_LOW_GAIN, MODE_MED_GAIN, MODE_HIGH_GAIN};
        internal_osc_clkout_mode = m inside {MODE_INT_IO, MODE_INT_CLKOUT};
        int_src = (q.freq == FREQ_LF_CODE) ? SRC_LF : SRC_HF;
        pri_src = internal_osc_clkout_mode ? int_src : SRC_EXT;

        ext_rise = ps.ext_clk & ~q.ext_prev;
        wake_rise = ps.wake & ~q.wake_prev;
        d.ext_prev = ps.ext_clk;
        d.wake_prev = ps.wake;
        d.high_freq_internal_stable = ps.hf_stable;
        d.low_freq_internal_stable = ps.lf_stable;

        // Start-up counter
        if (q.st == ST_INIT) begin
            d.cfg_mode = m;
            d.two_speed = ts_en;
            d.fail_safe_clock_monitor = fail_safe_clock_monitor_en;
            d.ost_done = ~crystal;
            d.ost_cnt = '0;
            d.ext_flag = ~(crystal & ts_en);
        end else if (wake_rise & crystal) begin
            d.ost_done = 1'b0;
            d.ost_cnt = '0;
            d.fail = 1'b0;
        end else if (~q.ost_done & ext_rise) begin
            d.ost_cnt = q.ost_cnt + 1'b1;
            if (q.ost_cnt == OST_LAST) begin
                d.ost_done = 1'b1;
                ev[IRQ_OST] = 1'b1;
            end
        end

        // Fail-safe watchdog on the oscillator pin
        if (q.fail_safe_clock_monitor & ~internal_osc_clkout_mode & q.ost_done & ~q.fail & (q.st != ST_INIT)) begin
            if (ext_rise) begin
                d.fail_cnt = '0;
            end else if (q.fail_cnt == FAIL_LAST) begin
                d.fail = 1'b1;
                ev[IRQ_FAIL] = 1'b1;
            end else begin
                d.fail_cnt = q.fail_cnt + 1'b1;
            end
        end else begin
            d.fail_cnt = '0;
        end

        // Wanted source
        if (q.system_clock_select | d.fail | (crystal & ts_en & ~d.ost_done)) begin
            tgt = int_src;
        end else begin
            tgt = pri_src;
        end

        // Break-before-make switching
        cur_clk = |(q.sel & {ps.lf_clk, ps.hf_clk, ps.ext_clk});
        new_clk = |(tgt & {ps.lf_clk, ps.hf_clk, ps.ext_clk});
        case (q.st)
            ST_INIT: begin
                d.st = ST_TAKE;
            end
            ST_RUN: begin
                if (tgt != q.sel) begin
                    d.st = ST_DROP;
                end
            end
            ST_DROP: begin
                if (~cur_clk | d.fail) begin
                    d.sel = SRC_NONE;
                    d.st = ST_TAKE;
                end
            end
            ST_TAKE: begin
                if (~new_clk) begin
                    d.sel = tgt;
                    d.ext_flag = (tgt == pri_src);
                    d.st = ST_RUN;
                    ev[IRQ_SWITCH] = 1'b1;
                end
            end
            default: begin
                d.st = ST_INIT;
            end
        endcase

        d.hold = (d.st != ST_RUN) | (crystal & ~ts_en & ~d.ost_done);

        // Pin roles and clock divided by four
        d.pin6_gpio = m inside {MODE_EXT_CLK, MODE_RC_IO, MODE_INT_IO};
        d.pin6_co = m inside {MODE_RC, MODE_INT_CLKOUT};
        d.pin7_gpio = internal_osc_clkout_mode;
        clk_rise = cur_clk & ~q.clk_prev;
        d.clk_prev = cur_clk;
        if (~d.pin6_co) begin
            d.div = 1'b0;
            d.pin6_clk = 1'b0;
        end else if (clk_rise) begin
            d.div = ~q.div;
            if (q.div) begin
                d.pin6_clk = ~q.pin6_clk;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Register writes in the data phase

        if (q.ap_valid & q.ap_write) begin
            case (q.ap_idx)
                OSC_CTRL_IDX: begin
                    d.freq = HWDATA_IN[FREQ_MSB:FREQ_LSB];
                    d.system_clock_select = HWDATA_IN[SCS_BIT];
                end
                IRQ_STAT_IDX: begin
                    w1c = HWDATA_IN[IRQ_W-1:0];
                end
                IRQ_MASK_IDX: begin
                    d.irq_mask = HWDATA_IN[IRQ_W-1:0];
                end
                default: begin
                    d.irq_mask = q.irq_mask;
                end
            endcase
        end

        // Set wins over a same-cycle clear
        d.irq_stat = (q.irq_stat & ~w1c) | ev;
        d.irq = |(d.irq_stat & d.irq_mask);

        ////////////////////////////////////////////////////////////////////////
        // Address phase and read data

        ap = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
        hit = (HADDR_IN[31:IDX_MSB+1] == '0) & (HADDR_IN[1:0] == 2'h0);
        if (ap) begin
            d.ap_valid = hit;
            d.ap_write = HWRITE_IN & (HSIZE_IN == HSIZE_WORD);
            d.ap_idx = HADDR_IN[IDX_MSB:IDX_LSB];
        end else begin
            d.ap_valid = 1'b0;
            d.ap_write = 1'b0;
        end

        case (d.ap_idx)
            OSC_CTRL_IDX: begin
                rd[FREQ_MSB:FREQ_LSB] = d.freq;
                rd[EXT_BIT] = d.ext_flag;
                rd[HTS_BIT] = d.high_freq_internal_stable;
                rd[LTS_BIT] = d.low_freq_internal_stable;
                rd[SCS_BIT] = d.system_clock_select;
            end
            IRQ_STAT_IDX: begin
                rd[IRQ_W-1:0] = d.irq_stat;
            end
            IRQ_MASK_IDX: begin
                rd[IRQ_W-1:0] = d.irq_mask;
            end
            INFO_IDX: begin
                rd[INFO_KHZ_MSB:0] = FREQ_KHZ[d.freq];
                rd[INFO_MODE_MSB:INFO_MODE_LSB] = d.cfg_mode;
                rd[INFO_OST_BIT] = d.ost_done;
                rd[INFO_FAIL_BIT] = d.fail;
                rd[INFO_SEL_MSB:INFO_SEL_LSB] = d.sel;
            end
            default: begin
                rd = '0;
            end
        endcase

        if (ap & ~HWRITE_IN) begin
            d.rdata = hit ? rd : '0;
        end
        d.rdy = 1'b1;
        d.resp = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= ST_INIT;
            q.cfg_mode <= MODE_LOW_GAIN;
            q.sel <= SRC_NONE;
            q.freq <= FREQ_RST;
            q.hold <= 1'b1;
            q.rdy <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign HRDATA_OUT = q.rdata;
    assign HREADYOUT_OUT = q.rdy;
    assign HRESP_OUT = q.resp;
    assign SRC_SEL_OUT = q.sel;
    assign HF_FREQ_SEL_OUT = q.freq;
    assign EXEC_HOLD_OUT = q.hold;
    assign PORTA_PIN6_GPIO_OUT = q.pin6_gpio;
    assign PORTA_PIN6_CLKOUT_OUT = q.pin6_co;
    assign PORTA_PIN6_CLK_OUT = q.pin6_clk;
    assign PORTA_PIN7_GPIO_OUT = q.pin7_gpio;
    assign IRQ_OUT = q.irq;

endmodule : sccs_top

// *** verification/sccs_top_asserts.sv ***
// Port-level checks for the clock source select top
`timescale 1ns/1ps
module sccs_top_asserts
    import sccs_pkg::*;
#(
    parameter int FAIL_SAFE_CLOCK_MONITOR_TIMEOUT_CYCLES = 40,
    parameter int OST_COUNT = 8
) (
    input wire logic CLOCK_IN,
    input wire logic NRST_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic [2:0] CLOCK_MODE_IN,
    input wire logic TWO_SPEED_STARTUP_ENABLE_IN,
    input wire logic FAIL_SAFE_CLOCK_MONITOR_IN,
    input wire logic OSC_PIN_CLK_IN,
    input wire logic WAKE_IN,
    input wire logic [2:0] SRC_SEL_OUT,
    input wire logic [2:0] HF_FREQ_SEL_OUT,
    input wire logic EXEC_HOLD_OUT,
    input wire logic PORTA_PIN6_GPIO_OUT,
    input wire logic PORTA_PIN6_CLKOUT_OUT,
    input wire logic PORTA_PIN6_CLK_OUT,
    input wire logic PORTA_PIN7_GPIO_OUT,
    input wire logic IRQ_OUT
);
    ////////////////////////////////////////////////////////////
    localparam logic [15:0] FAIL_LIM = 16'(FAIL_SAFE_CLOCK_MONITOR_TIMEOUT_CYCLES + 30);
    localparam logic [15:0] OST_LIM = 16'(OST_COUNT);
    logic [2:0] cyc_q;
    logic [15:0] rise_q;
    logic [15:0] idle_q;
    logic ext_q;
    logic xtal;
    logic taken;
    assign xtal = CLOCK_MODE_IN inside {MODE_LOW_GAIN, MODE_MED_GAIN, MODE_HIGH_GAIN};
    assign taken = HSEL_IN && HTRANS_IN[1] && HREADY_IN && HADDR_IN == 32'h0000023c;
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cyc_q <= 3'h0;
            rise_q <= 16'h0;
            idle_q <= 16'h0;
            ext_q <= 1'b0;
        end else begin
            ext_q <= OSC_PIN_CLK_IN;
            if (cyc_q != 3'h7) cyc_q <= cyc_q + 3'h1;
            if (WAKE_IN) rise_q <= 16'h0;
            else if (OSC_PIN_CLK_IN && !ext_q && rise_q != 16'hffff) rise_q <= rise_q + 16'h1;
            if (OSC_PIN_CLK_IN != ext_q) idle_q <= 16'h0;
            else if (idle_q != 16'hffff) idle_q <= idle_q + 16'h1;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!NRST_IN);
    property p_freq_wr;
        logic [2:0] v;
        (taken && HWRITE_IN && HSIZE_IN == 3'h2 ##1 (1'b1, v = HWDATA_IN[6:4])) |-> ##[1:2] HF_FREQ_SEL_OUT == v;
    endproperty
    a_sel_onehot: assert property ($onehot0(SRC_SEL_OUT))
        else $error("source select not one-hot");
    a_switch_gap: assert property ($changed(SRC_SEL_OUT) && $past(SRC_SEL_OUT) != 3'h0 |-> SRC_SEL_OUT == 3'h0)
        else $error("source changed without a gap");
    a_osc_rd_zero: assert property (taken && !HWRITE_IN |=> HRDATA_OUT[31:7] == 25'h0)
        else $error("upper control bits read nonzero");
    a_freq_wr_copy: assert property (p_freq_wr)
        else $error("frequency select not taken from write");
    a_pin6_role: assert property (cyc_q == 3'h7 |->
        PORTA_PIN6_GPIO_OUT == (CLOCK_MODE_IN inside {MODE_EXT_CLK, MODE_RC_IO, MODE_INT_IO}) &&
        PORTA_PIN6_CLKOUT_OUT == (CLOCK_MODE_IN inside {MODE_RC, MODE_INT_CLKOUT}))
        else $error("pin6 role wrong for mode");
    a_pin7_role: assert property (cyc_q == 3'h7 |->
        PORTA_PIN7_GPIO_OUT == (CLOCK_MODE_IN inside {MODE_INT_IO, MODE_INT_CLKOUT}))
        else $error("pin7 role wrong for mode");
    a_clk_quiet: assert property (!PORTA_PIN6_CLKOUT_OUT |-> !PORTA_PIN6_CLK_OUT)
        else $error("divided clock out while pin6 not clock");
    a_clk_div: assert property ($changed(PORTA_PIN6_CLK_OUT) |=> $stable(PORTA_PIN6_CLK_OUT)[*3])
        else $error("divided clock too fast");
    a_ost_hold: assert property ($fell(EXEC_HOLD_OUT) && xtal && !TWO_SPEED_STARTUP_ENABLE_IN &&
        !FAIL_SAFE_CLOCK_MONITOR_IN |-> rise_q >= OST_LIM)
        else $error("execution released before start-up count");
    a_fail_switch: assert property (FAIL_SAFE_CLOCK_MONITOR_IN && idle_q == FAIL_LIM |-> !SRC_SEL_OUT[0])
        else $error("dead external clock still selected");
    c_on_hf: cover property (SRC_SEL_OUT == 3'h2);
    c_irq: cover property ($rose(IRQ_OUT));
    c_run: cover property ($fell(EXEC_HOLD_OUT));
endmodule : sccs_top_asserts
////////////////////////////////////////////////////////////
bind sccs_top sccs_top_asserts #(.FAIL_SAFE_CLOCK_MONITOR_TIMEOUT_CYCLES(FAIL_SAFE_CLOCK_MONITOR_TIMEOUT_CYCLES), .OST_COUNT(OST_COUNT)) u_chk (
    .CLOCK_IN, .NRST_IN, .HSEL_IN, .HADDR_IN, .HTRANS_IN, .HWRITE_IN, .HSIZE_IN, .HWDATA_IN, .HREADY_IN,
    .HRDATA_OUT, .CLOCK_MODE_IN, .TWO_SPEED_STARTUP_ENABLE_IN, .FAIL_SAFE_CLOCK_MONITOR_IN, .OSC_PIN_CLK_IN,
    .WAKE_IN, .SRC_SEL_OUT, .HF_FREQ_SEL_OUT, .EXEC_HOLD_OUT, .PORTA_PIN6_GPIO_OUT, .PORTA_PIN6_CLKOUT_OUT,
    .PORTA_PIN6_CLK_OUT, .PORTA_PIN7_GPIO_OUT, .IRQ_OUT);

// *** verification/sccs_osc_model.sv ***
// Behavioural crystal and internal oscillators around the block
`timescale 1ns/1ps
module sccs_osc_model (
    input wire logic ext_run_in,
    output logic ext_clk_out,
    output logic hf_clk_out,
    output logic lf_clk_out,
    output logic hf_stable_out,
    output logic lf_stable_out
);
    initial begin
        ext_clk_out = 1'b0;
        forever #7 ext_clk_out = ext_run_in ? !ext_clk_out : 1'b0;
    end
    initial begin
        hf_clk_out = 1'b0;
        forever #6 hf_clk_out = !hf_clk_out;
    end
    initial begin
        lf_clk_out = 1'b0;
        forever #11 lf_clk_out = !lf_clk_out;
    end
    initial begin
        hf_stable_out = 1'b0;
        lf_stable_out = 1'b0;
        #150 hf_stable_out = 1'b1;
        #10 lf_stable_out = 1'b1;
    end
endmodule : sccs_osc_model

// *** verification/tb_system_clock_source_select.sv ***
// Self-checking bench for the clock source select block
`timescale 1ns/1ps
module tb_system_clock_source_select;
    import sccs_pkg::*;
    localparam logic [31:0] A_OSC = 32'h0000023c;
    localparam logic [31:0] A_STAT = 32'h00000240;
    localparam logic [31:0] A_MASK = 32'h00000244;
    localparam logic [31:0] A_INFO = 32'h00000248;
    localparam logic [15:0] KHZ [8] = '{16'h001f, 16'h007d, 16'h00fa, 16'h01f4, 16'h03e8, 16'h07d0, 16'h0fa0, 16'h1f40};
    localparam logic [2:0] PINS [8] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h5, 3'h3, 3'h4, 3'h2};
    logic clk, nrst, hsel, hwrite, ts, fs, ext_run, wake;
    logic [1:0] htrans;
    logic [2:0] hsize, mode;
    logic [31:0] haddr, hwdata;
    wire logic hready, hresp, ext_clk, hf_clk, lf_clk, hf_ok, lf_ok, hold, p6g, p6c, p6k, p7g, irq;
    wire logic [2:0] src, fsel;
    wire logic [31:0] hrdata;
    int bad_count, cmp_count, cycles;
    sccs_osc_model partner (.ext_run_in(ext_run), .ext_clk_out(ext_clk), .hf_clk_out(hf_clk), .lf_clk_out(lf_clk),
        .hf_stable_out(hf_ok), .lf_stable_out(lf_ok));
    sccs_top #(.FAIL_SAFE_CLOCK_MONITOR_TIMEOUT_CYCLES(40), .OST_COUNT(8)) dut (.CLOCK_IN(clk), .NRST_IN(nrst), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .CLOCK_MODE_IN(mode), .TWO_SPEED_STARTUP_ENABLE_IN(ts), .FAIL_SAFE_CLOCK_MONITOR_IN(fs),
        .OSC_PIN_CLK_IN(ext_clk), .HF_OSC_CLK_IN(hf_clk), .LF_OSC_CLK_IN(lf_clk), .HF_STABLE_IN(hf_ok),
        .LF_STABLE_IN(lf_ok), .WAKE_IN(wake), .SRC_SEL_OUT(src), .HF_FREQ_SEL_OUT(fsel), .EXEC_HOLD_OUT(hold),
        .PORTA_PIN6_GPIO_OUT(p6g), .PORTA_PIN6_CLKOUT_OUT(p6c), .PORTA_PIN6_CLK_OUT(p6k),
        .PORTA_PIN7_GPIO_OUT(p7g), .IRQ_OUT(irq));
    ////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        check(hrdata, exp);
        check({31'h0, hresp}, 32'h0);
    endtask : rdc
    task automatic wait_src(input logic [2:0] e);
        @(negedge clk);
        for (int n = 0; n < 400 && src !== e; n++) @(negedge clk);
        check({29'h0, src}, {29'h0, e});
        @(posedge clk);
    endtask : wait_src
    task automatic wait_irq(input logic e);
        @(negedge clk);
        for (int n = 0; n < 20 && irq !== e; n++) @(negedge clk);
        check({31'h0, irq}, {31'h0, e});
        @(posedge clk);
    endtask : wait_irq
    task automatic do_reset(input logic [2:0] m, input logic t, input logic f);
        nrst <= 1'b0;
        mode <= m;
        ts <= t;
        fs <= f;
        ext_run <= 1'b1;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : do_reset
    ////////////////////////////////////////////////////////////
    task automatic t_lp_start;
        do_reset(MODE_LOW_GAIN, 1'b0, 1'b0);
        @(negedge clk);
        check({31'h0, hold}, 32'h1);
        @(posedge clk);
        rdc(A_OSC, 32'h68);
        @(negedge clk);
        for (int n = 0; n < 400 && hold !== 1'b0; n++) @(negedge clk);
        check({31'h0, hold}, 32'h0);
        @(posedge clk);
        rdc(A_INFO, 32'h00280fa0);
    endtask : t_lp_start
    task automatic t_select;
        for (int i = 0; i < 8; i++) begin
            wr(A_OSC, 32'hffffff80 | (32'(i) << 4));
            rdc(A_OSC, (32'(i) << 4) | 32'h0e);
            rdc(A_INFO, {8'h0, 3'h1, 1'b0, 1'b1, 3'h0, KHZ[i]});
        end
        wr(A_OSC, 32'h71);
        wait_src(3'h2);
        rdc(A_OSC, 32'h77);
        wr(A_OSC, 32'h01);
        wait_src(3'h4);
        rdc(A_OSC, 32'h07);
        rdc(A_STAT, 32'h6);
        wait_irq(1'b0);
        wr(A_MASK, 32'h4);
        wait_irq(1'b1);
        wr(A_STAT, 32'h4);
        wait_irq(1'b0);
        rdc(A_STAT, 32'h2);
        wr(A_OSC, 32'h60);
        wait_src(3'h1);
        wait_irq(1'b1);
        rdc(A_OSC, 32'h6e);
        wr(A_MASK, 32'h0);
        wait_irq(1'b0);
        rdc(32'h00000300, 32'h0);
        wr(32'h0000023d, 32'h71);
        rdc(A_OSC, 32'h6e);
    endtask : t_select
    task automatic t_two_speed;
        do_reset(MODE_MED_GAIN, 1'b1, 1'b0);
        rdc(A_OSC, 32'h66);
        wait_src(3'h2);
        wait_src(3'h1);
        rdc(A_OSC, 32'h6e);
    endtask : t_two_speed
    task automatic t_fail;
        do_reset(MODE_HIGH_GAIN, 1'b0, 1'b1);
        rdc(A_OSC, 32'h66);
        wait_src(3'h2);
        wait_src(3'h1);
        wr(A_MASK, 32'h1);
        ext_run <= 1'b0;
        wait_src(3'h2);
        wait_irq(1'b1);
        rdc(A_INFO, {8'h0, 3'h2, 1'b1, 1'b1, 3'h2, 16'h0fa0});
        rdc(A_OSC, 32'h66);
        ext_run <= 1'b1;
        wake <= 1'b1;
        repeat (4) @(posedge clk);
        wake <= 1'b0;
        wait_src(3'h1);
    endtask : t_fail
    task automatic t_pins;
        int tg;
        logic last;
        for (int m = 3; m < 8; m++) begin
            do_reset(3'(m), 1'b0, 1'b0);
            wait_src((m == 4 || m == 5) ? 3'h2 : 3'h1);
            check({29'h0, p6g, p6c, p7g}, {29'h0, PINS[m]});
            check({31'h0, hold}, 32'h0);
            tg = 0;
            last = p6k;
            repeat (40) begin
                @(negedge clk);
                if (p6k !== last) tg++;
                last = p6k;
            end
            check({31'h0, tg != 0}, {31'h0, PINS[m][1]});
            @(posedge clk);
            rdc(A_OSC, 32'h6e);
        end
    endtask : t_pins
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = HSIZE_WORD;
        haddr = 32'h0;
        hwdata = 32'h0;
        mode = 3'h0;
        ts = 1'b0;
        fs = 1'b0;
        ext_run = 1'b1;
        wake = 1'b0;
        @(posedge clk);
        t_lp_start();
        t_select();
        t_two_speed();
        t_fail();
        t_pins();
        conclude();
    end
endmodule : tb_system_clock_source_select
